// file: rtl/dsp_instruction_decode.sv
// Decoder for 24-bit program words: operand fields, two-word handling, cycle counts, flag classes.
// Assumes the fetch unit offers one word per word_valid cycle and cond_true/skip_taken alongside it.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_decode_defs.svh"

module dsp_instruction_decode (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic word_valid,
   input wire logic [23:0] word,
   input wire logic cond_true,
   input wire logic skip_taken,
   output logic dec_valid,
   output logic [7:0] dec_opcode,
   output logic dec_nop,
   output logic [1:0] cycles,
   output logic word2_err,
   output logic [12:0] file_addr,
   output logic file_dest_work,
   output logic [3:0] bit_select_field,
   output logic [9:0] imm_ten_bit,
   output logic imm_byte_mode,
   output logic imm_range_err,
   output logic [22:0] abs_target_literal,
   output logic acc_sel,
   output logic [3:0] awb_reg,
   output logic awb_postinc,
   output logic [3:0] mul_src_a,
   output logic [3:0] mul_src_b,
   output logic mul_pair_err,
   output logic x_prefetch_en,
   output logic [3:0] x_prefetch_addr,
   output logic [3:0] x_step,
   output logic x_offset_w12,
   output logic [3:0] x_dest_reg,
   output logic y_prefetch_en,
   output logic [3:0] y_prefetch_addr,
   output logic [3:0] y_step,
   output logic y_offset_w12,
   output logic [3:0] y_dest_reg,
   output logic [3:0] second_src_reg,
   output logic [3:0] signed_shift_literal,
   output logic [8:0] flag_update,
   output logic skip_done,
   output logic [1:0] skip_cycles
);

   // ******************************
   // Decode helpers
   // ******************************
   function automatic logic is_two_word(input logic [7:0] o);
      is_two_word = (o == `OPC_CALL_ABS) || (o == `OPC_GOTO_ABS) || (o == `OPC_DO_LOOP);
   endfunction

   function automatic logic [1:0] cyc_of(input logic [7:0] o, input logic c);
      case (o)
         `OPC_JUMP_COND: cyc_of = c ? `CYC_TWO : `CYC_ONE;
         `OPC_JUMP_ALWAYS, `OPC_JUMP_COMPUTED, `OPC_CALL_IND, `OPC_GOTO_IND: cyc_of = `CYC_TWO;
         `OPC_TBL: cyc_of = `CYC_TBL;
         `OPC_RETURN, `OPC_INT_RETURN: cyc_of = `CYC_RET;
         `OPC_MOVD: cyc_of = `CYC_TWO;
         `OPC_CALL_ABS, `OPC_GOTO_ABS, `OPC_DO_LOOP: cyc_of = `CYC_TWO;
         default: cyc_of = `CYC_ONE;
      endcase
   endfunction

   function automatic logic [8:0] flags_of(input logic [7:0] o);
      case (o)
         `OPC_ADD_FILE, `OPC_ADD_LIT: flags_of = `FLAGS_ARITH;
         `OPC_AND_FILE, `OPC_AND_LIT: flags_of = `FLAGS_LOGIC;
         `OPC_ADD_ACC: flags_of = `FLAGS_ACC;
         `OPC_SHR_ONE: flags_of = `FLAGS_SHR_ONE;
         `OPC_SHR_MULTI: flags_of = `FLAGS_LOGIC;
         default: flags_of = `FLAGS_NONE;
      endcase
   endfunction

   // Codes 0..5 name the six distinct pairs; the rest are flagged and fall back to the first pair.
   function automatic logic [8:0] pair_of(input logic [2:0] p);
      case (p)
         3'h0: pair_of = {1'b0, 4'h4, 4'h5};
         3'h1: pair_of = {1'b0, 4'h4, 4'h6};
         3'h2: pair_of = {1'b0, 4'h4, 4'h7};
         3'h3: pair_of = {1'b0, 4'h5, 4'h6};
         3'h4: pair_of = {1'b0, 4'h5, 4'h7};
         3'h5: pair_of = {1'b0, 4'h6, 4'h7};
         default: pair_of = {1'b1, 4'h4, 4'h5};
      endcase
   endfunction

   // Low code bits pick the step; code 4 means no prefetch on the low register, W12 offset on the high one.
   function automatic dsp_decode_pkg::prefetch_s pf_of(input logic [3:0] code, input logic [3:0] base);
      dsp_decode_pkg::prefetch_s r;
      r.en = (code != 4'h4);
      r.addr = base + {3'h0, code[3]};
      r.w12 = (code == 4'hc);
      case (code[2:0])
         3'h1: r.step = 4'h2;
         3'h2: r.step = 4'h4;
         3'h3: r.step = 4'h6;
         3'h5: r.step = 4'ha;
         3'h6: r.step = 4'hc;
         3'h7: r.step = 4'he;
         default: r.step = 4'h0;
      endcase
      pf_of = r;
   endfunction

   // ******************************
   // Fetch sequencing
   // ******************************
   dsp_decode_pkg::fetch_state_e state;
   dsp_decode_pkg::fetch_state_e next_state;
   logic [23:0] held;
   logic [23:0] dw;
   logic [7:0] opc;
   logic [7:0] word_opc;
   logic in_first;
   logic in_second;
   logic take_first;
   logic first_two;
   logic skip_go;
   logic emit;
   logic next_skip_done;

   assign word_opc = word[`F_OPC_HI:`F_OPC_LO];
   assign in_first = (state == dsp_decode_pkg::st_first);
   assign in_second = (state == dsp_decode_pkg::st_second);
   assign dw = in_second ? held : word;
   assign opc = dw[`F_OPC_HI:`F_OPC_LO];
   assign take_first = in_first && word_valid;
   assign first_two = take_first && is_two_word(word_opc);
   assign skip_go = take_first && (word_opc == `OPC_SKIP) && skip_taken;
   assign emit = (take_first && !first_two) || (in_second && word_valid);
   assign next_skip_done = word_valid && ((state == dsp_decode_pkg::st_skip_second) ||
                           ((state == dsp_decode_pkg::st_skip) && !is_two_word(word_opc)));

   always_comb begin
      next_state = state;
      if (word_valid) begin
         case (state)
            dsp_decode_pkg::st_first: begin
               if (first_two)
                  next_state = dsp_decode_pkg::st_second;
               else if (skip_go)
                  next_state = dsp_decode_pkg::st_skip;
               else
                  next_state = dsp_decode_pkg::st_first;
            end
            dsp_decode_pkg::st_skip: begin
               if (is_two_word(word_opc))
                  next_state = dsp_decode_pkg::st_skip_second;
               else
                  next_state = dsp_decode_pkg::st_first;
            end
            default: next_state = dsp_decode_pkg::st_first;
         endcase
      end
   end

   // ******************************
   // Operand decode
   // ******************************
   logic byte_mode;
   logic [9:0] imm_raw;
   logic [3:0] sq_reg;
   logic [8:0] pair;
   dsp_decode_pkg::prefetch_s xpf;
   dsp_decode_pkg::prefetch_s ypf;

   assign byte_mode = dw[`F_IMM_BYTE];
   assign imm_raw = dw[`F_IMM_HI:`F_IMM_LO];
   assign sq_reg = `REG_DSP_BASE + {2'h0, dw[`F_PAIR_LO+1:`F_PAIR_LO]};
   assign pair = (opc == `OPC_SQR) ? {1'b0, sq_reg, sq_reg} : pair_of(dw[`F_PAIR_HI:`F_PAIR_LO]);
   assign xpf = pf_of(dw[`F_X_HI:`F_X_LO], `REG_X_BASE);
   assign ypf = pf_of(dw[`F_Y_HI:`F_Y_LO], `REG_Y_BASE);

   // ******************************
   // Registered outputs
   // ******************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= dsp_decode_pkg::st_first;
         held <= 24'h000000;
         dec_valid <= 1'b0;
         skip_done <= 1'b0;
         skip_cycles <= 2'h0;
      end else begin
         state <= next_state;
         if (first_two)
            held <= word;
         dec_valid <= emit;
         skip_done <= next_skip_done;
         if (next_skip_done)
            skip_cycles <= (state == dsp_decode_pkg::st_skip_second) ? `CYC_THREE : `CYC_TWO;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dec_opcode <= 8'h00;
         dec_nop <= 1'b0;
         cycles <= 2'h0;
         word2_err <= 1'b0;
         abs_target_literal <= 23'h000000;
         flag_update <= 9'h000;
      end else if (emit) begin
         dec_opcode <= opc;
         dec_nop <= (opc == `OPC_NOP);
         cycles <= cyc_of(opc, cond_true);
         word2_err <= in_second && (word_opc != `F_W2_TOP);
         if (in_second)
            abs_target_literal <= {word[`F_TGT_W2_HI:0], held[15:1], 1'b0};
         flag_update <= flags_of(opc);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         file_addr <= 13'h0000;
         file_dest_work <= 1'b0;
         bit_select_field <= 4'h0;
         imm_ten_bit <= 10'h000;
         imm_byte_mode <= 1'b0;
         imm_range_err <= 1'b0;
      end else if (emit) begin
         file_addr <= dw[`F_FILE_HI:0];
         file_dest_work <= dw[`F_FILE_DEST];
         bit_select_field <= dw[`F_BIT_HI:`F_BIT_LO];
         imm_ten_bit <= byte_mode ? {2'h0, imm_raw[7:0]} : imm_raw;
         imm_byte_mode <= byte_mode;
         imm_range_err <= byte_mode && (imm_raw[9:8] != 2'h0);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         acc_sel <= 1'b0;
         awb_reg <= 4'h0;
         awb_postinc <= 1'b0;
         {mul_pair_err, mul_src_a, mul_src_b} <= 9'h000;
         {x_prefetch_en, x_prefetch_addr, x_step, x_offset_w12} <= 10'h000;
         {y_prefetch_en, y_prefetch_addr, y_step, y_offset_w12} <= 10'h000;
         x_dest_reg <= 4'h0;
         y_dest_reg <= 4'h0;
         second_src_reg <= 4'h0;
         signed_shift_literal <= 4'h0;
      end else if (emit) begin
         acc_sel <= dw[`F_ACC];
         awb_reg <= `REG_AWB;
         awb_postinc <= (opc == `OPC_MAC_AWB);
         {mul_pair_err, mul_src_a, mul_src_b} <= pair;
         {x_prefetch_en, x_prefetch_addr, x_step, x_offset_w12} <= xpf;
         {y_prefetch_en, y_prefetch_addr, y_step, y_offset_w12} <= ypf;
         x_dest_reg <= `REG_DSP_BASE + {2'h0, dw[`F_XD_HI:`F_XD_LO]};
         y_dest_reg <= `REG_DSP_BASE + {2'h0, dw[`F_YD_HI:`F_YD_LO]};
         second_src_reg <= dw[`F_SRC_HI:`F_SRC_LO];
         signed_shift_literal <= dw[`F_SLIT_HI:`F_SLIT_LO];
      end
   end

   // ******************************
   // Checks
   // ******************************
   reset_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(rst_n) |-> state == dsp_decode_pkg::st_first) else $error("decoder not in first-word state after reset");
   first_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      first_two |=> !dec_valid && in_second) else $error("first of two words was issued alone");
   two_cycles_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      in_second && word_valid |=> dec_valid && cycles == 2'h2) else $error("two-word op not two cycles");
   stray_nop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_first && word_opc == 8'h00 |=> dec_valid && dec_nop) else $error("lone second word not a nop");
   skip_two_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state == dsp_decode_pkg::st_skip && word_valid && !is_two_word(word_opc) |=> skip_done && skip_cycles == 2'h2)
      else $error("skip over one word not two cycles");
   skip_three_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state == dsp_decode_pkg::st_skip_second && word_valid |=> skip_done && skip_cycles == 2'h3)
      else $error("skip over two words not three cycles");
   cond_branch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_first && word_opc == 8'h30 |=> cycles == (($past(cond_true)) ? 2'h2 : 2'h1))
      else $error("conditional branch cycle count wrong");
   asr_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_first && word_opc == 8'hde |=> flag_update == 9'h014) else $error("multi-bit shift flags wrong");
   target_even_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      in_second && word_valid |=> !abs_target_literal[0] && abs_target_literal[22:16] == $past(word[6:0]))
      else $error("call target literal odd or misplaced");
   byte_imm_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      dec_valid && imm_byte_mode |-> imm_ten_bit[9:8] == 2'h0) else $error("byte literal above 255");

endmodule
`default_nettype wire

// file: rtl/dsp_decode_defs.svh
// Constants for the program word decoder: opcodes, field positions, cycle counts and flag masks.
// Assumes inclusion by bare name from the design files.
`ifndef DSP_DECODE_DEFS_SVH
`define DSP_DECODE_DEFS_SVH

// ******************************
// Word layout
// ******************************
`define F_OPC_HI 23
`define F_OPC_LO 16
`define F_W2_TOP 8'h00
`define F_FILE_HI 12
`define F_FILE_DEST 13
`define F_BIT_HI 15
`define F_BIT_LO 12
`define F_IMM_HI 13
`define F_IMM_LO 4
`define F_IMM_BYTE 14
`define F_ACC 15
`define F_PAIR_HI 14
`define F_PAIR_LO 12
`define F_X_HI 11
`define F_X_LO 8
`define F_Y_HI 7
`define F_Y_LO 4
`define F_XD_HI 3
`define F_XD_LO 2
`define F_YD_HI 1
`define F_YD_LO 0
`define F_SLIT_HI 7
`define F_SLIT_LO 4
`define F_SRC_HI 3
`define F_SRC_LO 0
`define F_TGT_W2_HI 6

// ******************************
// Opcodes
// ******************************
`define OPC_NOP 8'h00
`define OPC_JUMP_COMPUTED 8'h01
`define OPC_CALL_ABS 8'h02
`define OPC_CALL_IND 8'h03
`define OPC_GOTO_ABS 8'h04
`define OPC_GOTO_IND 8'h05
`define OPC_RETURN 8'h06
`define OPC_INT_RETURN 8'h07
`define OPC_DO_LOOP 8'h08
`define OPC_TBL 8'h0a
`define OPC_JUMP_COND 8'h30
`define OPC_JUMP_ALWAYS 8'h37
`define OPC_SKIP 8'ha0
`define OPC_BIT_FILE 8'ha8
`define OPC_ADD_LIT 8'hb0
`define OPC_AND_LIT 8'hb2
`define OPC_ADD_FILE 8'hb4
`define OPC_AND_FILE 8'hb6
`define OPC_MOVD 8'hbe
`define OPC_MAC 8'hc0
`define OPC_MAC_AWB 8'hc1
`define OPC_ADD_ACC 8'hc9
`define OPC_SHR_ONE 8'hd1
`define OPC_SHR_MULTI 8'hde
`define OPC_SQR 8'hf0

// ******************************
// Cycle counts, registers, flags
// ******************************
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3
`define CYC_TBL 2'h2
`define CYC_RET 2'h3
`define REG_AWB 4'hd
`define REG_DSP_BASE 4'h4
`define REG_X_BASE 4'h8
`define REG_Y_BASE 4'ha
`define FLAGS_NONE 9'h000
`define FLAGS_ARITH 9'h01f
`define FLAGS_LOGIC 9'h014
`define FLAGS_SHR_ONE 9'h01d
`define FLAGS_ACC 9'h1e0

`endif

// file: rtl/dsp_decode_pkg.sv
// Types shared by the program word decoder.
// Assumes nothing of its surroundings.
package dsp_decode_pkg;
   typedef enum logic [1:0] {st_first, st_second, st_skip, st_skip_second} fetch_state_e;
   typedef struct packed {
      logic en;
      logic [3:0] addr;
      logic [3:0] step;
      logic w12;
   } prefetch_s;
endpackage

// file: testbench/program_fetch_model.sv
// Program memory fetch model that offers one 24-bit word per request cycle to the decoder.
// Assumes the bench raises req just after a falling clock edge and holds it for whole cycles.
`timescale 1ns/1ps
`default_nettype none

module program_fetch_model (
   input wire logic ref_clk,
   input wire logic req,
   input wire logic [23:0] req_word,
   input wire logic req_cond,
   input wire logic req_skip,
   output logic word_valid,
   output logic [23:0] word,
   output logic cond_true,
   output logic skip_taken
);
   logic [23:0] last = 24'h000000;

   // Outside a request the bus shows the inverse of the last word, so a stale value never looks valid.
   always_comb begin
      word_valid = req;
      word = req ? req_word : ~last;
      cond_true = req ? req_cond : 1'b0;
      skip_taken = req ? req_skip : 1'b0;
   end

   always_ff @(posedge ref_clk) begin
      if (req) begin
         last <= req_word;
      end
   end
endmodule
`default_nettype wire

// file: testbench/dsp_instruction_decode_tb.sv
// Self-checking bench for the program word decoder.
// Assumes the fetch model in its own file and the decoder's one-cycle answer after each taken word.
`timescale 1ns/1ps
`default_nettype none

module dsp_instruction_decode_tb;
   logic ref_clk = 1'b0, rst_n = 1'b0, req = 1'b0, req_cond = 1'b0, req_skip = 1'b0;
   logic [23:0] req_word = 24'h000000;
   logic word_valid, cond_true, skip_taken, dec_valid, dec_nop, word2_err, file_dest_work;
   logic [23:0] word;
   logic [7:0] dec_opcode;
   logic [1:0] cycles, skip_cycles;
   logic [12:0] file_addr;
   logic [3:0] bit_select_field, awb_reg, mul_src_a, mul_src_b, x_prefetch_addr, x_step, x_dest_reg;
   logic [3:0] y_prefetch_addr, y_step, y_dest_reg, second_src_reg, signed_shift_literal;
   logic [9:0] imm_ten_bit;
   logic [22:0] abs_target_literal;
   logic [8:0] flag_update;
   logic imm_byte_mode, imm_range_err, acc_sel, awb_postinc, mul_pair_err, x_prefetch_en, x_offset_w12;
   logic y_prefetch_en, y_offset_w12, skip_done;
   int miscompares = 0, num_checks = 0;
   logic [7:0] cop [10] = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h30, 8'h30, 8'h37, 8'hbe};
   logic [1:0] ccy [10] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2};
   logic [7:0] two_op [3] = '{8'h02, 8'h04, 8'h08};
   logic [3:0] pa [6] = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6};
   logic [3:0] pb [6] = '{4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h7};
   logic [3:0] pcode [5] = '{4'h0, 4'h3, 4'h5, 4'hc, 4'hf};
   logic [3:0] pstep [5] = '{4'h0, 4'h6, 4'ha, 4'h0, 4'he};
   logic [3:0] pofs [5] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h1};

   program_fetch_model program_fetch_model_i (.ref_clk, .req, .req_word, .req_cond, .req_skip,
      .word_valid, .word, .cond_true, .skip_taken);

   dsp_instruction_decode dsp_instruction_decode_i (.ref_clk, .rst_n, .word_valid, .word, .cond_true,
      .skip_taken, .dec_valid, .dec_opcode, .dec_nop, .cycles, .word2_err, .file_addr, .file_dest_work,
      .bit_select_field, .imm_ten_bit, .imm_byte_mode, .imm_range_err, .abs_target_literal, .acc_sel,
      .awb_reg, .awb_postinc, .mul_src_a, .mul_src_b, .mul_pair_err, .x_prefetch_en, .x_prefetch_addr,
      .x_step, .x_offset_w12, .x_dest_reg, .y_prefetch_en, .y_prefetch_addr, .y_step, .y_offset_w12,
      .y_dest_reg, .second_src_reg, .signed_shift_literal, .flag_update, .skip_done, .skip_cycles);

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   // ************************************
   // Access and compare tasks
   // ************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask

   // Offers one word; returns in the cycle where its decode result stands.
   task automatic send(input logic [23:0] w, input logic c, input logic s);
      req = 1'b1;
      req_word = w;
      req_cond = c;
      req_skip = s;
      @(negedge ref_clk);
   endtask

   task automatic idle();
      req = 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic results();
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      results();
   end

   // ************************************
   // Scenarios
   // ************************************
   initial begin
      repeat (10) @(negedge ref_clk);
      chk(dec_valid, 0);
      chk(abs_target_literal, 0);
      rst_n = 1'b1;
      send(24'hb40123, 0, 0);
      chk({dec_valid, dec_opcode, cycles}, {1'b1, 8'hb4, 2'h1});
      chk({flag_update, file_addr, file_dest_work}, {9'h01f, 13'h0123, 1'b0});
      send(24'hb43fff, 0, 0);
      chk({file_addr, file_dest_work}, {13'h1fff, 1'b1});
      send(24'hb62005, 0, 0);
      chk({flag_update, file_addr, file_dest_work}, {9'h014, 13'h0005, 1'b1});
      for (int i = 0; i < 3; i++) begin
         send({two_op[i], 16'h0247}, 0, 0);
         chk(dec_valid, 0);
         send(24'h000005, 0, 0);
         chk({dec_valid, dec_opcode, cycles, word2_err}, {1'b1, two_op[i], 2'h2, 1'b0});
      end
      send(24'h020247, 0, 0);
      send(24'h010005, 0, 0);
      chk({word2_err, abs_target_literal}, {1'b1, 23'h050246});
      send(24'h000005, 0, 0);
      chk({dec_valid, dec_nop, cycles}, {1'b1, 1'b1, 2'h1});
      for (int i = 0; i < 10; i++) begin
         send({cop[i], 16'h0000}, i == 7, 0);
         chk({dec_valid, cycles}, {1'b1, ccy[i]});
      end
      send(24'ha00000, 0, 1);
      chk({dec_valid, cycles}, {1'b1, 2'h1});
      send(24'h020000, 0, 0);
      chk(dec_valid, 0);
      send(24'h000000, 0, 0);
      chk({dec_valid, skip_done, skip_cycles}, {1'b0, 1'b1, 2'h3});
      send(24'ha00000, 0, 1);
      send(24'hb40000, 0, 0);
      chk({dec_valid, skip_done, skip_cycles}, {1'b0, 1'b1, 2'h2});
      send(24'ha00000, 0, 0);
      send(24'hb40000, 0, 0);
      chk({dec_valid, dec_opcode, skip_done}, {1'b1, 8'hb4, 1'b0});
      send(24'ha8f000, 0, 0);
      chk(bit_select_field, 4'hf);
      send(24'hb03ff0, 0, 0);
      chk({imm_ten_bit, imm_byte_mode, imm_range_err}, {10'h3ff, 1'b0, 1'b0});
      send(24'hb07ff0, 0, 0);
      chk({imm_ten_bit, imm_byte_mode, imm_range_err}, {10'h0ff, 1'b1, 1'b1});
      for (int i = 0; i < 6; i++) begin
         send({8'hc1, 1'b1, 3'(i), 12'h000}, 0, 0);
         chk({mul_src_a, mul_src_b, mul_pair_err, acc_sel}, {pa[i], pb[i], 1'b0, 1'b1});
         chk({awb_reg, awb_postinc}, {4'hd, 1'b1});
      end
      send(24'hc00000, 0, 0);
      chk({awb_reg, awb_postinc}, {4'hd, 1'b0});
      send(24'hf03000, 0, 0);
      chk({mul_src_a, mul_src_b}, {4'h7, 4'h7});
      send(24'hc07000, 0, 0);
      chk({mul_src_a, mul_src_b, mul_pair_err}, {4'h4, 4'h5, 1'b1});
      for (int i = 0; i < 5; i++) begin
         send({8'hc0, 4'h0, pcode[i], pcode[i], 4'hd}, 0, 0);
         chk({x_prefetch_en, x_prefetch_addr, x_step, x_offset_w12}, {1'b1, 4'h8 + pofs[i], pstep[i],
            pcode[i] == 4'hc});
         chk({y_prefetch_en, y_prefetch_addr, y_step, y_offset_w12}, {1'b1, 4'ha + pofs[i], pstep[i],
            pcode[i] == 4'hc});
         chk({x_dest_reg, y_dest_reg}, {4'h7, 4'h5});
      end
      send(24'hc00440, 0, 0);
      chk({x_prefetch_en, y_prefetch_en}, 2'h0);
      send(24'hc90000, 0, 0);
      chk(flag_update, 9'h1e0);
      send(24'hd10000, 0, 0);
      chk(flag_update, 9'h01d);
      send(24'hde0053, 0, 0);
      chk({flag_update, signed_shift_literal, second_src_reg}, {9'h014, 4'h5, 4'h3});
      send(24'h020000, 0, 0);
      req = 1'b0;
      rst_n = 1'b0;
      @(negedge ref_clk);
      rst_n = 1'b1;
      send(24'hb40123, 0, 0);
      chk({dec_valid, dec_opcode}, {1'b1, 8'hb4});
      idle();
      results();
   end
endmodule
`default_nettype wire
